// [shared/rpm_defs.svh]
// constants for the receive process-data mapper
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH
`define RPM_IDX_COMM 16'h1400
`define RPM_IDX_MAP 16'h1600
`define RPM_IDX_MASK 16'hFFF8
`define RPM_SUB_CNT 8'h00
`define RPM_SUB_ID 8'h01
`define RPM_SUB_TT 8'h02
`define RPM_ABT_OK 32'h0000_0000
`define RPM_ABT_STATE 32'h0800_0022
`define RPM_ABT_LEN 32'h0604_0042
`define RPM_ABT_OBJ 32'h0604_0041
`define RPM_ABT_RO 32'h0601_0002
`define RPM_ABT_NOOBJ 32'h0602_0000
`define RPM_ABT_NOSUB 32'h0609_0011
`define RPM_ABT_HIGH 32'h0609_0031
`define RPM_FIX_ID 11'h200
`define RPM_FIX_STEP 11'h100
`define RPM_COB_VALID 31
`define RPM_TT_SYNC_MAX 8'hF0
`define RPM_TT_RES_MAX 8'hFD
`define RPM_TT_RST 8'hFF
`define RPM_MAX_BITS 9'h040
`define RPM_DUM_I8 16'h0002
`define RPM_DUM_I16 16'h0003
`define RPM_DUM_I32 16'h0004
`define RPM_DUM_U8 16'h0005
`define RPM_DUM_U16 16'h0006
`define RPM_DUM_U32 16'h0007
`define RPM_APP_LO 16'h2000
`define RPM_LEN8 8'h08
`define RPM_LEN16 8'h10
`define RPM_LEN32 8'h20
`endif

// [shared/rpm_pkg.sv]
// types for the receive process-data mapper
`default_nettype none
package rpm_pkg;
	typedef enum logic [1:0] {
		RPM_NMT_STOP  = 2'h0,
		RPM_NMT_PREOP = 2'h1,
		RPM_NMT_OP    = 2'h2,
		RPM_NMT_INIT  = 2'h3
	} rpm_nmt_t;
	typedef enum logic [1:0] {
		RPM_IDLE = 2'h0,
		RPM_SCAT = 2'h1,
		RPM_SYNC = 2'h3
	} rpm_fsm_t;
	typedef struct packed {
		logic [10:0] id;
		logic [3:0]  len;
		logic [63:0] data;
	} rpm_frame_t;
	typedef struct packed {
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} rpm_cfg_t;
	typedef struct packed {
		logic [15:0] index;
		logic [7:0]  sub;
		logic [7:0]  bits;
		logic [31:0] data;
	} rpm_od_t;
endpackage
`default_nettype wire

// [verilog/rpm_rx_mapper.sv]
// receive process-data mapper: channel config, frame match, payload scatter
`timescale 1ns/1ns
`default_nettype none
`include "rpm_defs.svh"
module rpm_rx_mapper #(
	parameter int NCH  = 8,
	parameter int NE   = 15,
	parameter int NFIX = 4
) (
	input  wire logic               clock_i,
	input  wire logic               sys_rst_i,
	input  wire rpm_pkg::rpm_nmt_t  nmt_state_i,
	input  wire logic [6:0]         node_id_i,
	input  wire logic               comm_restart_i,
	input  wire logic               sync_i,
	input  wire logic               rx_valid_i,
	input  wire rpm_pkg::rpm_frame_t rx_frame_i,
	output logic                    rx_ready_o,
	output logic                    rx_drop_o,
	input  wire logic               cfg_valid_i,
	input  wire rpm_pkg::rpm_cfg_t  cfg_i,
	output logic                    cfg_done_o,
	output logic [31:0]             cfg_abort_o,
	output logic                    od_valid_o,
	output rpm_pkg::rpm_od_t        od_o,
	input  wire logic               od_ready_i,
	output logic [NCH-1:0]          sync_pend_o
);
	localparam int CW = $clog2(NCH);
	localparam int EW = $clog2(NE + 1);

	typedef struct packed {
		rpm_pkg::rpm_fsm_t            st;
		logic                         rdy;
		logic                         sreq;
		logic                         done;
		logic                         drop;
		logic                         v0;
		logic                         v1;
		logic [NCH-1:0]               pend;
		logic [NCH-1:0]               mask;
		logic [NCH-1:0][63:0]         sbuf;
		logic [63:0]                  work;
		logic [CW-1:0]                wch;
		logic [EW-1:0]                e;
		logic [8:0]                   off;
		logic [NCH-1:0][EW-1:0]       cnt;
		logic [NCH-1:0][7:0]          tt;
		logic [NCH-1:0][NE-1:0][31:0] map;
		logic [NCH-1:0][11:0]         cpend;
		logic [NCH-1:0][11:0]         cact;
		rpm_pkg::rpm_od_t             s0;
		rpm_pkg::rpm_od_t             s1;
		logic [31:0]                  abort;
	} rpm_state_t;

	rpm_state_t          r_reg;
	rpm_state_t          r_next;
	logic [NCH-1:0][10:0] eff_id;
	logic [NCH-1:0]      match;
	logic                hit;
	logic [CW-1:0]       hc;
	logic                taken;
	logic                op;
	logic                cnt0;
	logic                short_f;
	logic                is_comm;
	logic                is_map;
	logic [CW-1:0]       cc;
	logic [31:0]         ent;
	logic                dum;
	logic                push;
	logic                pop;
	logic [31:0]         ab;
	rpm_pkg::rpm_od_t    pw;

	function automatic logic [8:0] tot_bits(input logic [NE-1:0][31:0] m,
		input logic [EW-1:0] n);
		logic [8:0] s;
		s = '0;
		for (int i = 0; i < NE; i++)
			if (i < int'(n))
				s = s + {1'b0, m[i][7:0]};
		return s;
	endfunction

	function automatic logic obj_ok(input logic [15:0] idx, input logic [7:0] len);
		logic ok;
		ok = 1'b0;
		case (idx)
			`RPM_DUM_I8, `RPM_DUM_U8:   ok = (len == `RPM_LEN8);
			`RPM_DUM_I16, `RPM_DUM_U16: ok = (len == `RPM_LEN16);
			`RPM_DUM_I32, `RPM_DUM_U32: ok = (len == `RPM_LEN32);
			default: ok = (idx >= `RPM_APP_LO) && (len == `RPM_LEN8 ||
				len == `RPM_LEN16 || len == `RPM_LEN32);
		endcase
		return ok;
	endfunction

	function automatic logic [31:0] slice(input logic [63:0] w, input logic [8:0] off,
		input logic [7:0] len);
		logic [63:0] s;
		s = w >> off;
		case (len)
			`RPM_LEN8:  return 32'(s[7:0]);
			`RPM_LEN16: return 32'(s[15:0]);
			default:    return s[31:0];
		endcase
	endfunction

	// fixed channels ignore the stored id bits, only the valid flag counts
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		if (g < NFIX)
		begin : g_fix
			assign eff_id[g] = `RPM_FIX_ID + `RPM_FIX_STEP * 11'(g) + {4'h0, node_id_i};
		end
		else
		begin : g_free
			assign eff_id[g] = r_reg.cact[g][10:0];
		end
		assign match[g] = !r_reg.cact[g][11] && (eff_id[g] == rx_frame_i.id);
	end

	always_comb
	begin
		hit = 1'b0;
		hc = '0;
		for (int i = NCH - 1; i >= 0; i--)
			if (match[i])
			begin
				hit = 1'b1;
				hc = CW'(i);
			end
	end

	assign op      = (nmt_state_i == rpm_pkg::RPM_NMT_OP);
	assign taken   = rx_valid_i && r_reg.rdy;
	assign cnt0    = (r_reg.cnt[hc] == '0);
	assign short_f = tot_bits(r_reg.map[hc], r_reg.cnt[hc]) >
		{2'b00, rx_frame_i.len, 3'b000};
	assign is_comm = ((cfg_i.index & `RPM_IDX_MASK) == `RPM_IDX_COMM);
	assign is_map  = ((cfg_i.index & `RPM_IDX_MASK) == `RPM_IDX_MAP);
	assign cc      = cfg_i.index[CW-1:0];
	assign ent     = (r_reg.e < EW'(NE)) ? r_reg.map[r_reg.wch][r_reg.e] : '0;
	assign dum     = (ent[31:16] >= `RPM_DUM_I8) && (ent[31:16] <= `RPM_DUM_U32);
	assign pop     = r_reg.v0 && od_ready_i;

	always_comb
	begin
		r_next = r_reg;
		push = 1'b0;
		pw = '0;
		ab = `RPM_ABT_OK;
		r_next.done = cfg_valid_i;
		r_next.drop = 1'b0;
		r_next.sreq = r_reg.sreq | sync_i;
		if (comm_restart_i)
			r_next.cact = r_reg.cpend;
		if (cfg_valid_i)
		begin
			if (!is_comm && !is_map)
				ab = `RPM_ABT_NOOBJ;
			else if (op)
				ab = `RPM_ABT_STATE;
			else if (is_comm)
			begin
				case (cfg_i.sub)
					`RPM_SUB_CNT: ab = `RPM_ABT_RO;
					`RPM_SUB_ID:
						if (int'(cc) < NFIX)
							r_next.cpend[cc][11] = cfg_i.data[`RPM_COB_VALID];
						else
							r_next.cpend[cc] = {cfg_i.data[`RPM_COB_VALID],
								cfg_i.data[10:0]};
					`RPM_SUB_TT:
						if (cfg_i.data[7:0] > `RPM_TT_SYNC_MAX &&
							cfg_i.data[7:0] <= `RPM_TT_RES_MAX)
							ab = `RPM_ABT_HIGH;
						else
							r_next.tt[cc] = cfg_i.data[7:0];
					default: ab = `RPM_ABT_NOSUB;
				endcase
			end
			else if (cfg_i.sub == `RPM_SUB_CNT)
			begin
				if (cfg_i.data > 32'(NE))
					ab = `RPM_ABT_HIGH;
				else if (tot_bits(r_reg.map[cc], cfg_i.data[EW-1:0]) > `RPM_MAX_BITS)
					ab = `RPM_ABT_LEN;
				else
					r_next.cnt[cc] = cfg_i.data[EW-1:0];
			end
			else if (cfg_i.sub <= 8'(NE))
			begin
				if (!obj_ok(cfg_i.data[31:16], cfg_i.data[7:0]))
					ab = `RPM_ABT_OBJ;
				else if (tot_bits(r_reg.map[cc], EW'(cfg_i.sub - 8'h01)) +
					{1'b0, cfg_i.data[7:0]} > `RPM_MAX_BITS)
					ab = `RPM_ABT_LEN;
				else
					r_next.map[cc][EW'(cfg_i.sub - 8'h01)] = cfg_i.data;
			end
			else
				ab = `RPM_ABT_NOSUB;
		end
		r_next.abort = ab;
		case (r_reg.st)
			rpm_pkg::RPM_IDLE:
			begin
				if (r_reg.sreq)
				begin
					r_next.mask = r_reg.pend;
					r_next.pend = '0;
					r_next.sreq = sync_i;
					if (r_reg.pend != '0)
						r_next.st = rpm_pkg::RPM_SYNC;
				end
				else if (taken && op && hit)
				begin
					if (cnt0 || short_f)
						r_next.drop = 1'b1;
					else if (r_reg.tt[hc] <= `RPM_TT_SYNC_MAX)
					begin
						r_next.sbuf[hc] = rx_frame_i.data;
						r_next.pend[hc] = 1'b1;
					end
					else
					begin
						r_next.work = rx_frame_i.data;
						r_next.wch = hc;
						r_next.e = '0;
						r_next.off = '0;
						r_next.st = rpm_pkg::RPM_SCAT;
					end
				end
			end
			rpm_pkg::RPM_SYNC:
			begin
				for (int i = NCH - 1; i >= 0; i--)
					if (r_reg.mask[i])
						r_next.wch = CW'(i);
				r_next.mask[r_next.wch] = 1'b0;
				r_next.work = r_reg.sbuf[r_next.wch];
				r_next.e = '0;
				r_next.off = '0;
				r_next.st = (r_reg.mask != '0) ? rpm_pkg::RPM_SCAT : rpm_pkg::RPM_IDLE;
			end
			rpm_pkg::RPM_SCAT:
			begin
				if (r_reg.e >= r_reg.cnt[r_reg.wch])
					r_next.st = (r_reg.mask != '0) ? rpm_pkg::RPM_SYNC : rpm_pkg::RPM_IDLE;
				else if (dum || !r_reg.v1)
				begin
					push = !dum;
					pw = '{index: ent[31:16], sub: ent[15:8], bits: ent[7:0],
						data: slice(r_reg.work, r_reg.off, ent[7:0])};
					r_next.off = r_reg.off + {1'b0, ent[7:0]};
					r_next.e = r_reg.e + 1'b1;
				end
			end
			default: r_next.st = rpm_pkg::RPM_IDLE;
		endcase
		// two-slot skid: slot 0 is the output register itself
		if (pop)
		begin
			if (r_reg.v1)
			begin
				r_next.s0 = r_reg.s1;
				r_next.v1 = 1'b0;
			end
			else if (push)
				r_next.s0 = pw;
			else
				r_next.v0 = 1'b0;
		end
		else if (push)
		begin
			if (!r_reg.v0)
			begin
				r_next.s0 = pw;
				r_next.v0 = 1'b1;
			end
			else
			begin
				r_next.s1 = pw;
				r_next.v1 = 1'b1;
			end
		end
		// a pending sync blocks new frames so buffered data stays coherent
		r_next.rdy = (r_next.st == rpm_pkg::RPM_IDLE) && !r_next.sreq;
		if (sys_rst_i)
		begin
			r_next = '0;
			r_next.rdy = 1'b1;
			for (int i = 0; i < NCH; i++)
			begin
				r_next.tt[i] = `RPM_TT_RST;
				r_next.cpend[i][11] = (i >= NFIX);
				r_next.cact[i][11] = (i >= NFIX);
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		r_reg <= r_next;
	end

	assign rx_ready_o  = r_reg.rdy;
	assign rx_drop_o   = r_reg.drop;
	assign cfg_done_o  = r_reg.done;
	assign cfg_abort_o = r_reg.abort;
	assign od_valid_o  = r_reg.v0;
	assign od_o        = r_reg.s0;
	assign sync_pend_o = r_reg.pend;

	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	not_oper_a: assert property (taken && !op |=>
		r_reg.st == rpm_pkg::RPM_IDLE && $stable(r_reg.pend) && !rx_drop_o)
		else $error("frame processed outside operational");
	cfg_state_a: assert property (cfg_valid_i && op && (is_comm || is_map) |=>
		cfg_done_o && cfg_abort_o == `RPM_ABT_STATE && $stable(r_reg.map))
		else $error("config write accepted while operational");
	map_len_a: assert property (cfg_valid_i && !op && is_map &&
		cfg_i.sub == `RPM_SUB_CNT && cfg_i.data <= 32'(NE) &&
		tot_bits(r_reg.map[cc], cfg_i.data[EW-1:0]) > `RPM_MAX_BITS |=>
		cfg_abort_o == `RPM_ABT_LEN && $stable(r_reg.cnt))
		else $error("overlong mapping accepted");
	map_obj_a: assert property (cfg_valid_i && !op && is_map &&
		cfg_i.sub != `RPM_SUB_CNT && cfg_i.sub <= 8'(NE) &&
		!obj_ok(cfg_i.data[31:16], cfg_i.data[7:0]) |=> cfg_abort_o == `RPM_ABT_OBJ)
		else $error("non mappable object accepted");
	tt_resv_a: assert property (cfg_valid_i && !op && is_comm &&
		cfg_i.sub == `RPM_SUB_TT && cfg_i.data[7:0] > `RPM_TT_SYNC_MAX &&
		cfg_i.data[7:0] <= `RPM_TT_RES_MAX |=>
		cfg_abort_o == `RPM_ABT_HIGH && $stable(r_reg.tt))
		else $error("reserved transmission type stored");
	id_hold_a: assert property (!comm_restart_i |=> $stable(r_reg.cact))
		else $error("identifier changed without restart");
	sync_buf_a: assert property (taken && op && hit && !cnt0 && !short_f &&
		r_reg.tt[hc] <= `RPM_TT_SYNC_MAX |=>
		r_reg.pend[$past(hc)] && r_reg.st == rpm_pkg::RPM_IDLE &&
		r_reg.sbuf[$past(hc)] == $past(rx_frame_i.data))
		else $error("synchronous frame not held for sync");
	async_a: assert property (taken && op && hit && !cnt0 && !short_f &&
		r_reg.tt[hc] > `RPM_TT_SYNC_MAX |=> r_reg.st == rpm_pkg::RPM_SCAT)
		else $error("asynchronous frame not applied");
	drop_a: assert property (taken && op && hit && (cnt0 || short_f) |=>
		rx_drop_o && r_reg.st == rpm_pkg::RPM_IDLE && $stable(r_reg.pend))
		else $error("bad frame not dropped");
	hold_out_a: assert property (od_valid_o && !od_ready_i |=>
		od_valid_o && $stable(od_o))
		else $error("buffered word lost under stall");

	async_c: cover property (taken && op && hit && r_reg.tt[hc] > `RPM_TT_SYNC_MAX
		##[1:40] od_valid_o);
	sync_c: cover property (r_reg.st == rpm_pkg::RPM_SYNC ##[1:40] od_valid_o);
	stall_c: cover property (r_reg.v1 && !od_ready_i [*3]);
	abort_c: cover property (cfg_done_o && cfg_abort_o == `RPM_ABT_LEN);
endmodule
`default_nettype wire

// [test/rpm_od_sink.sv]
// object-dictionary receiver model, answers promptly or with stalls
`timescale 1ns/1ns
`default_nettype none
module rpm_od_sink (
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	input  wire logic slow_i,
	output logic      od_ready_o = 1'h0
);
	logic [1:0] ph_reg;
	// slow mode takes one word in four cycles, so the two-slot buffer fills
	always @(negedge clock_i)
	begin
		ph_reg <= sys_rst_i ? 2'h0 : ph_reg + 2'h1;
		od_ready_o <= !slow_i || ph_reg == 2'h3;
	end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking testbench for the receive process-data mapper
`timescale 1ns/1ns
`default_nettype none
`include "rpm_defs.svh"
module tb_top;
	logic                clock_i = 1'h0;
	logic                sys_rst_i = 1'h1;
	rpm_pkg::rpm_nmt_t   nmt_state_i = rpm_pkg::RPM_NMT_PREOP;
	logic [6:0]          node_id_i = 7'h00;
	logic                comm_restart_i = 1'h0;
	logic                sync_i = 1'h0;
	logic                rx_valid_i = 1'h0;
	rpm_pkg::rpm_frame_t rx_frame_i = '0;
	logic                cfg_valid_i = 1'h0;
	rpm_pkg::rpm_cfg_t   cfg_i = '0;
	logic                slow = 1'h0;
	logic                rx_ready_o, rx_drop_o, cfg_done_o, od_valid_o, od_ready_i;
	logic [31:0]         cfg_abort_o;
	rpm_pkg::rpm_od_t    od_o;
	logic [7:0]          sync_pend_o;
	logic [63:0]         cfg_q[$];
	logic [63:0]         od_q[$];
	logic [31:0]         seed;
	logic [63:0]         d;
	logic [10:0]         nid;
	int                  failures = 0;
	int                  checked = 0;
	int                  drops = 0;
	int                  n;

	always #10 clock_i = ~clock_i;

	rpm_rx_mapper rpm_rx_mapper_i (.clock_i, .sys_rst_i, .nmt_state_i, .node_id_i,
		.comm_restart_i, .sync_i, .rx_valid_i, .rx_frame_i, .rx_ready_o, .rx_drop_o,
		.cfg_valid_i, .cfg_i, .cfg_done_o, .cfg_abort_o, .od_valid_o, .od_o,
		.od_ready_i, .sync_pend_o);
	rpm_od_sink rpm_od_sink_i (.clock_i, .sys_rst_i, .slow_i(slow), .od_ready_o(od_ready_i));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic pop_chk(ref logic [63:0] q[$], input logic [63:0] got);
		// an output with nothing expected is a mismatch by itself
		if (q.size() == 0)
			chk(got, ~got);
		else
			chk(got, q.pop_front());
	endtask

	task end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// leaves cfg_valid_i high so writes can run back to back
	task automatic cfg(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v,
		input logic [31:0] ab);
		cfg_i = '{ix, sb, v};
		cfg_valid_i = 1'h1;
		cfg_q.push_back(64'(ab));
		@(negedge clock_i);
	endtask

	task automatic frame(input logic [10:0] id, input logic [3:0] len);
		n = 0;
		while (rx_ready_o !== 1'h1 && n < 300)
		begin
			@(negedge clock_i);
			n++;
		end
		// a ready that never comes is a failure of its own
		if (n >= 300)
			failures++;
		rx_frame_i = '{id, len, d};
		rx_valid_i = 1'h1;
		@(negedge clock_i);
		rx_valid_i = 1'h0;
		// one idle cycle so back-to-back frames never re-raise valid in one step
		@(negedge clock_i);
	endtask

	task automatic expod(input logic [31:0] hi, input logic [31:0] v);
		od_q.push_back({hi, v});
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge clock_i);
		s = 1'h0;
	endtask

	always @(posedge clock_i)
	begin
		if (cfg_done_o === 1'h1)
			pop_chk(cfg_q, 64'(cfg_abort_o));
		if (od_valid_o === 1'h1 && od_ready_i === 1'h1)
			pop_chk(od_q, od_o);
		if (rx_drop_o === 1'h1)
			drops++;
	end

	initial
	begin
		#400_000;
		failures++;
		end_sim;
	end

	initial
	begin
		seed = 32'h0000_36b2;
		nid = 11'(rnd() & 32'h0000_007f);
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		sys_rst_i = 1'h0;
		node_id_i = nid[6:0];
		cfg(16'h1600, 8'h01, 32'h6040_0010, `RPM_ABT_OK);
		cfg(16'h1600, 8'h02, 32'h607a_0020, `RPM_ABT_OK);
		cfg(16'h1600, 8'h03, 32'h6041_0020, `RPM_ABT_LEN);
		cfg(16'h1600, 8'h03, 32'h0001_0008, `RPM_ABT_OBJ);
		cfg(16'h1600, 8'h00, 32'h0000_0002, `RPM_ABT_OK);
		cfg(16'h1400, 8'h02, 32'h0000_00fe, `RPM_ABT_OK);
		cfg(16'h1400, 8'h02, 32'h0000_00f1, `RPM_ABT_HIGH);
		cfg(16'h1400, 8'h02, 32'h0000_00fd, `RPM_ABT_HIGH);
		cfg(16'h1400, 8'h03, 32'h0000_0000, `RPM_ABT_NOSUB);
		cfg(16'h1408, 8'h00, 32'h0000_0000, `RPM_ABT_NOOBJ);
		cfg(16'h1401, 8'h02, 32'h0000_00f0, `RPM_ABT_OK);
		cfg(16'h1601, 8'h01, 32'h0005_0008, `RPM_ABT_OK);
		cfg(16'h1601, 8'h02, 32'h6060_0008, `RPM_ABT_OK);
		cfg(16'h1601, 8'h00, 32'h0000_0002, `RPM_ABT_OK);
		cfg(16'h1404, 8'h01, 32'h0000_0123, `RPM_ABT_OK);
		cfg(16'h1604, 8'h01, 32'h6200_0020, `RPM_ABT_OK);
		cfg(16'h1604, 8'h00, 32'h0000_0001, `RPM_ABT_OK);
		// entries written out of order so only the count check can refuse
		cfg(16'h1605, 8'h03, 32'h6200_0020, `RPM_ABT_OK);
		cfg(16'h1605, 8'h01, 32'h6200_0020, `RPM_ABT_OK);
		cfg(16'h1605, 8'h02, 32'h6200_0020, `RPM_ABT_OK);
		cfg(16'h1605, 8'h00, 32'h0000_0003, `RPM_ABT_LEN);
		cfg(16'h1605, 8'h00, 32'h0000_0010, `RPM_ABT_HIGH);
		// id bits ignored on a fixed channel, only the disable flag is kept
		cfg(16'h1402, 8'h01, 32'h8000_0123, `RPM_ABT_OK);
		cfg_valid_i = 1'h0;
		d = {rnd(), rnd()};
		frame(11'h200 + nid, 4'h8);
		nmt_state_i = rpm_pkg::RPM_NMT_OP;
		cfg(16'h1600, 8'h00, 32'h0000_0001, `RPM_ABT_STATE);
		cfg_valid_i = 1'h0;
		for (int k = 0; k < 2; k++)
		begin
			slow = k[0];
			d = {rnd(), rnd()};
			expod({16'h6040, 8'h00, 8'h10}, {16'h0000, d[15:0]});
			expod({16'h607a, 8'h00, 8'h20}, d[47:16]);
			frame(11'h200 + nid, 4'h6);
		end
		frame(11'h200 + nid, 4'h5);
		frame(11'h400 + nid, 4'h8);
		// sync channel: nothing leaves until the sync pulse
		d = {rnd(), rnd()};
		frame(11'h300 + nid, 4'h2);
		repeat (4) @(negedge clock_i);
		chk(64'(sync_pend_o), 64'h0000_0000_0000_0002);
		expod({16'h6060, 8'h00, 8'h08}, {24'h00_0000, d[15:8]});
		pulse(sync_i);
		// new identifier stays inactive until restart
		frame(11'h123, 4'h4);
		repeat (4) @(negedge clock_i);
		pulse(comm_restart_i);
		expod({16'h6200, 8'h00, 8'h20}, d[31:0]);
		frame(11'h123, 4'h4);
		// channel 2 now disabled: no drop may be counted
		frame(11'h400 + nid, 4'h8);
		n = 0;
		while ((od_q.size() != 0 || cfg_q.size() != 0) && n < 500)
		begin
			@(negedge clock_i);
			n++;
		end
		repeat (5) @(negedge clock_i);
		chk(64'(od_q.size()), 64'h0000_0000_0000_0000);
		chk(64'(cfg_q.size()), 64'h0000_0000_0000_0000);
		chk(64'(drops), 64'h0000_0000_0000_0002);
		end_sim;
	end
endmodule
`default_nettype wire
